//--- bench/hmws_halt_seq_tb.sv
// self-checking bench for the halt entry and wake sequencer
`timescale 1ns/1ps
module hmws_halt_seq_tb;
  import hmws_pkg::*;
  localparam int LOCK_CYC = 8;

  logic          sys_clk_i;
  logic          rst_n_i;
  logic          idle_halt_i;
  hmws_dsel_type clock_divide_select_i;
  logic          crystal_source_i;
  logic          pll_used_i;
  logic          osc_stable_i;
  logic          wake_pin_i;
  logic          wake_int_en_i;
  logic          flash_sleep_i;
  logic          ext_mem_busy_i;
  logic          core_clk_en_o;
  logic          periph_clk_en_o;
  logic          pll_en_o;
  logic          osc_en_o;
  logic          external_clock_output_en_o;
  logic          halted_o;
  logic          cpu_resume_o;
  logic          wake_irq_o;
  logic          ext_mem_fail_o;
  logic          wake_req;
  logic [3:0]    wake_hold;
  int            mismatches = 0;
  int            samples_checked = 0;
  int            cycles = 0;

  hmws_halt_seq #(.LOCK_CYC(LOCK_CYC), .LOCK_W(18)) dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .idle_halt_i(idle_halt_i),
    .clock_divide_select_i(clock_divide_select_i), .crystal_source_i(crystal_source_i),
    .pll_used_i(pll_used_i), .osc_stable_i(osc_stable_i), .wake_pin_i(wake_pin_i),
    .wake_int_en_i(wake_int_en_i), .flash_sleep_i(flash_sleep_i),
    .ext_mem_busy_i(ext_mem_busy_i), .core_clk_en_o(core_clk_en_o),
    .periph_clk_en_o(periph_clk_en_o), .pll_en_o(pll_en_o), .osc_en_o(osc_en_o),
    .external_clock_output_en_o(external_clock_output_en_o), .halted_o(halted_o),
    .cpu_resume_o(cpu_resume_o), .wake_irq_o(wake_irq_o), .ext_mem_fail_o(ext_mem_fail_o)
  );

  hmws_wake_source wake_src (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .wake_req_i(wake_req),
    .osc_stable_i(osc_stable_i), .hold_i(wake_hold), .wake_pin_o(wake_pin_i)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // hang guard: whole run is under two thousand cycles
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 10000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one full halt entry, wake, lock and resume
  task automatic halt_cycle(input hmws_dsel_type dsel, input logic xtal, input logic pll,
                            input logic flash, input logic irq, input logic busy,
                            input logic [3:0] hold);
    int   n;
    int   k;
    int   kc;
    int   kx;
    logic fail_seen;
    n = (dsel == 2'h3) ? 64 : ((dsel == 2'h2) ? 32 : 16);
    @(posedge sys_clk_i);
    clock_divide_select_i <= dsel;
    crystal_source_i      <= xtal;
    pll_used_i            <= pll;
    flash_sleep_i         <= flash;
    wake_int_en_i         <= irq;
    ext_mem_busy_i        <= busy;
    wake_hold             <= hold;
    idle_halt_i           <= 1'b1;
    @(posedge sys_clk_i);
    idle_halt_i <= 1'b0;
    kc = 0;
    kx = 0;
    fail_seen = 1'b0;
    for (k = 1; k <= 70; k++) begin
      @(posedge sys_clk_i);
      #1;
      if (core_clk_en_o === 1'b0 && kc == 0) kc = k;
      if (external_clock_output_en_o === 1'b0 && kx == 0) kx = k;
      if (ext_mem_fail_o === 1'b1) fail_seen = 1'b1;
    end
    check(kc, n);
    check(kx, 32);
    check(fail_seen, busy);
    check(periph_clk_en_o, 1'b0);
    check(pll_en_o, 1'b0);
    check(osc_en_o, !xtal);
    check(halted_o, 1'b1);
    @(posedge sys_clk_i);
    ext_mem_busy_i <= 1'b0;
    osc_stable_i   <= 1'b0;
    // requested far past the four-cycle floor after idle
    wake_req       <= 1'b1;
    @(posedge sys_clk_i);
    wake_req <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    #1;
    check(osc_en_o, 1'b1);
    check(halted_o, 1'b1);
    @(posedge sys_clk_i);
    osc_stable_i <= 1'b1;
    @(posedge sys_clk_i);
    #1;
    check(pll_en_o, pll);
    k = 0;
    while (core_clk_en_o !== 1'b1 && k < 300) begin
      @(posedge sys_clk_i);
      #1;
      k++;
    end
    check(k, LOCK_CYC);
    check(periph_clk_en_o, 1'b1);
    check(halted_o, 1'b0);
    k = 0;
    while (cpu_resume_o !== 1'b1 && k < 1200) begin
      @(posedge sys_clk_i);
      #1;
      k++;
    end
    check(k, flash ? 1125 : 35);
    check(wake_irq_o, irq);
    @(posedge sys_clk_i);
    #1;
    check(cpu_resume_o, 1'b0);
  endtask

  // reset while halted brings every clock back at once
  task automatic reset_in_halt();
    @(posedge sys_clk_i);
    clock_divide_select_i <= 2'h0;
    idle_halt_i           <= 1'b1;
    @(posedge sys_clk_i);
    idle_halt_i <= 1'b0;
    repeat (40) @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    check(core_clk_en_o, 1'b1);
    check(halted_o, 1'b0);
    @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
  endtask

  initial begin
    rst_n_i               = 1'b0;
    idle_halt_i           = 1'b0;
    clock_divide_select_i = 2'h0;
    crystal_source_i      = 1'b1;
    pll_used_i            = 1'b1;
    osc_stable_i          = 1'b1;
    wake_int_en_i         = 1'b0;
    flash_sleep_i         = 1'b0;
    ext_mem_busy_i        = 1'b0;
    wake_req              = 1'b0;
    wake_hold             = 4'h0;
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    halt_cycle(2'h0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 4'h0);
    halt_cycle(2'h1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 4'h3);
    halt_cycle(2'h2, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 4'h7);
    halt_cycle(2'h3, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 4'h2);
    reset_in_halt();
    halt_cycle(2'h0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 4'h1);
    end_of_test();
  end
endmodule

//--- bench/hmws_wake_source.sv
// wake source model: pulls the wake pin low and lets go hold_i cycles after the oscillator settles
`timescale 1ns/1ps
module hmws_wake_source (
  input  wire logic       sys_clk_i,     // system clock
  input  wire logic       rst_n_i,       // async reset, active low
  input  wire logic       wake_req_i,    // start a wake, one cycle
  input  wire logic       osc_stable_i,  // oscillator has settled
  input  wire logic [3:0] hold_i,        // extra low cycles after settle
  output logic            wake_pin_o     // wake pin, active low
);
  logic       low_reg;
  logic       low_next;
  logic [3:0] hold_reg;
  logic [3:0] hold_next;

  always_comb begin
    low_next  = low_reg;
    hold_next = hold_reg;
    if (wake_req_i) begin
      low_next  = 1'b1;
      hold_next = hold_i;
    end else if (low_reg && osc_stable_i) begin
      // pin held low until the oscillator is settled
      if (hold_reg == 4'h0) begin
        low_next = 1'b0;
      end else begin
        hold_next = hold_reg - 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_reg  <= 1'b0;
      hold_reg <= 4'h0;
    end else begin
      low_reg  <= low_next;
      hold_reg <= hold_next;
    end
  end

  // released pin sits at its pull-up level
  assign wake_pin_o = ~low_reg;
endmodule

//--- core/hmws_cnt_if.sv
// load, run and count signals between the sequencer and a down counter
`timescale 1ns/1ps
interface hmws_cnt_if #(
  parameter int W = 11
);
  logic         load;
  logic         run;
  logic [W-1:0] load_val;
  logic [W-1:0] count;
  logic         done;

  modport user    (output load, output run, output load_val, input count, input done);
  modport counter (input load, input run, input load_val, output count, output done);
endinterface

//--- core/hmws_down_counter.sv
// loadable down counter, done while the count stands at one
`timescale 1ns/1ps
module hmws_down_counter #(
  parameter int W = 11
) (
  input  wire logic   sys_clk_i,  // system clock
  input  wire logic   rst_n_i,    // async reset, active low
  hmws_cnt_if.counter cnt_if      // load, run, count
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (cnt_if.load) begin
      cnt_next = cnt_if.load_val;
    end else if (cnt_if.run && (cnt_reg != '0)) begin
      cnt_next = cnt_reg - W'(1);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign cnt_if.count = cnt_reg;
  assign cnt_if.done  = (cnt_reg == W'(1));
endmodule

//--- core/hmws_halt_seq.sv
// halt entry flush, clock shutdown, wake, lock wait and resume sequencer
`timescale 1ns/1ps
// Behaviour
// [RULE1] flush 16/32/64 cycles by divide select
// [RULE2] external access outlasting flush is flagged failed
// [RULE3] halted: peripheral clocks and pll off
// [RULE4] crystal source: oscillator off while halted
// [RULE5] low wake pin restarts oscillator
// [RULE6] wake source holds pin until oscillator stable
// [RULE7] lock wait of 131072 oscillator cycles
// [RULE8] lock wait applies even without pll
// [RULE9] lock end re-enables clocks, then wake interrupt
// [RULE10] no wake before 4 cycles after idle
// [RULE11] external clock low 32..45 cycles after idle
// [RULE12] resume within 1125 flash, 35 ram cycles
// [RULE13] lock counter reloaded on every halt entry
module hmws_halt_seq
  import hmws_pkg::*;
#(
  parameter int LOCK_CYC = hmws_pkg::LOCK_CYC_DEF,  // lock interval, cycles
  parameter int LOCK_W   = hmws_pkg::LOCK_W_DEF     // lock counter width
) (
  input  wire logic                   sys_clk_i,                   // system clock
  input  wire logic                   rst_n_i,                     // async reset, active low
  input  wire logic                   idle_halt_i,                 // idle executed, halt chosen
  input  wire hmws_pkg::hmws_dsel_type clock_divide_select_i,      // divider setting
  input  wire logic                   crystal_source_i,            // crystal or resonator used
  input  wire logic                   pll_used_i,                  // pll enabled by software
  input  wire logic                   osc_stable_i,                // oscillator has settled
  input  wire logic                   wake_pin_i,                  // selected wake pin
  input  wire logic                   wake_int_en_i,               // wake interrupt enabled
  input  wire logic                   flash_sleep_i,               // resuming from sleeping flash
  input  wire logic                   ext_mem_busy_i,              // external access pending
  output logic                        core_clk_en_o,               // core clock gate
  output logic                        periph_clk_en_o,             // peripheral clock gate
  output logic                        pll_en_o,                    // pll power
  output logic                        osc_en_o,                    // oscillator power
  output logic                        external_clock_output_en_o,  // external clock gate
  output logic                        halted_o,                    // in halt mode
  output logic                        cpu_resume_o,                // execution resumes, pulse
  output logic                        wake_irq_o,                  // wake interrupt, pulse
  output logic                        ext_mem_fail_o               // access cut by halt, pulse
);
  hmws_state_type     st_reg;
  hmws_state_type     st_next;
  hmws_entry_cnt_type entry_reg;
  hmws_entry_cnt_type entry_next;
  logic               core_reg;
  logic               core_next;
  logic               periph_reg;
  logic               periph_next;
  logic               pll_reg;
  logic               pll_next;
  logic               osc_reg;
  logic               osc_next;
  logic               xclk_reg;
  logic               xclk_next;
  logic               halted_reg;
  logic               halted_next;
  logic               resume_reg;
  logic               resume_next;
  logic               irq_reg;
  logic               irq_next;
  logic               fail_reg;
  logic               fail_next;
  logic               clk_on_next;

  logic               seq_load;
  logic               seq_run;
  hmws_seq_cnt_type   seq_val;
  logic               lock_load;
  logic               lock_run;
  logic               wake_low;
  logic               wake_fall;

  hmws_cnt_if #(.W(SEQ_CNT_W)) seq_if ();
  hmws_cnt_if #(.W(LOCK_W))    lock_if ();

  assign seq_if.load      = seq_load;
  assign seq_if.run       = seq_run;
  assign seq_if.load_val  = seq_val;
  assign lock_if.load     = lock_load;
  assign lock_if.run      = lock_run;
  assign lock_if.load_val = LOCK_W'(LOCK_CYC);

  hmws_down_counter #(.W(SEQ_CNT_W)) u_seq_cnt (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .cnt_if    (seq_if)
  );

  // counts sys_clk_i cycles; held while halted, runs only in lock
  hmws_down_counter #(.W(LOCK_W)) u_lock_cnt (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .cnt_if    (lock_if)
  );

  hmws_wake_detect u_wake (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .wake_pin_i  (wake_pin_i),
    .wake_low_o  (wake_low),
    .wake_fall_o (wake_fall)
  );

  // sequencing
  always_comb begin
    st_next     = st_reg;
    seq_load    = 1'b0;
    seq_run     = 1'b1;
    seq_val     = SEQ_CNT_RST;
    lock_load   = 1'b0;
    lock_run    = 1'b0;
    resume_next = 1'b0;
    irq_next    = 1'b0;
    fail_next   = 1'b0;
    case (st_reg)
      ST_RUN: begin
        if (idle_halt_i) begin
          st_next  = ST_FLUSH;
          seq_load = 1'b1;
          seq_val  = hmws_flush_len(clock_divide_select_i);  // [RULE1]
        end
      end
      ST_FLUSH: begin
        if (seq_if.done) begin
          st_next   = ST_HALTED;  // [RULE1]
          fail_next = ext_mem_busy_i;  // [RULE2]
          lock_load = 1'b1;  // [RULE13]
        end
      end
      ST_HALTED: begin
        // early wakes are left pending until the minimum gap has passed
        if ((entry_reg >= MIN_WAKE_CYC) && (wake_low || wake_fall)) begin  // [RULE10]
          st_next = ST_OSC_WAIT;  // [RULE5]
        end
      end
      ST_OSC_WAIT: begin
        // pin is expected to stay low up to here, so no re-check  [RULE6]
        if (osc_stable_i) begin
          st_next = ST_LOCK;
        end
      end
      ST_LOCK: begin
        lock_run = 1'b1;  // [RULE8]
        if (lock_if.done) begin
          st_next  = ST_RESUME;  // [RULE7]
          seq_load = 1'b1;
          seq_val  = flash_sleep_i ? RESUME_FLASH_CYC : RESUME_SINGLE_ACCESS_RAM_CYC;  // [RULE12]
        end
      end
      ST_RESUME: begin
        if (seq_if.done) begin
          st_next     = ST_RUN;
          resume_next = 1'b1;  // [RULE12]
          irq_next    = wake_int_en_i;  // [RULE9]
        end
      end
      default: begin
        st_next = ST_RUN;
      end
    endcase
  end

  // clock, power and pin gates follow the next state
  always_comb begin
    entry_next = entry_reg;
    if (st_next == ST_RUN) begin
      entry_next = ENTRY_CNT_RST;
    end else if (entry_reg != XCLK_LOW_CYC) begin
      entry_next = entry_reg + 6'h01;
    end
    clk_on_next = (st_next == ST_RUN) || (st_next == ST_FLUSH) || (st_next == ST_RESUME);
    core_next   = clk_on_next;  // [RULE9]
    periph_next = clk_on_next;  // [RULE3]
    pll_next    = (clk_on_next || (st_next == ST_LOCK)) && pll_used_i;  // [RULE3]
    osc_next    = (st_next == ST_HALTED) ? !crystal_source_i : 1'b1;  // [RULE4]
    // stays up through the 32nd cycle after idle, then low until ST_RESUME or ST_RUN
    xclk_next   = (st_next == ST_RUN) || (st_next == ST_RESUME) ||
                  (entry_reg < XCLK_LOW_CYC);  // [RULE11]
    halted_next = (st_next == ST_HALTED) || (st_next == ST_OSC_WAIT) ||
                  (st_next == ST_LOCK);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg     <= ST_RUN;
      entry_reg  <= ENTRY_CNT_RST;
      core_reg   <= 1'b1;
      periph_reg <= 1'b1;
      pll_reg    <= 1'b1;
      osc_reg    <= 1'b1;
      xclk_reg   <= 1'b1;
      halted_reg <= 1'b0;
      resume_reg <= 1'b0;
      irq_reg    <= 1'b0;
      fail_reg   <= 1'b0;
    end else begin
      st_reg     <= st_next;
      entry_reg  <= entry_next;
      core_reg   <= core_next;
      periph_reg <= periph_next;
      pll_reg    <= pll_next;
      osc_reg    <= osc_next;
      xclk_reg   <= xclk_next;
      halted_reg <= halted_next;
      resume_reg <= resume_next;
      irq_reg    <= irq_next;
      fail_reg   <= fail_next;
    end
  end

  assign core_clk_en_o              = core_reg;
  assign periph_clk_en_o            = periph_reg;
  assign pll_en_o                   = pll_reg;
  assign osc_en_o                   = osc_reg;
  assign external_clock_output_en_o = xclk_reg;
  assign halted_o                   = halted_reg;
  assign cpu_resume_o               = resume_reg;
  assign wake_irq_o                 = irq_reg;
  assign ext_mem_fail_o             = fail_reg;

  // cycles spent in lock, for checking only
  logic [LOCK_W-1:0] lock_obs_reg;
  logic [LOCK_W-1:0] lock_obs_next;

  always_comb begin
    lock_obs_next = '0;
    if (st_reg == ST_LOCK) begin
      lock_obs_next = lock_obs_reg + LOCK_W'(1);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_obs_reg <= '0;
    end else begin
      lock_obs_reg <= lock_obs_next;
    end
  end

  a_flush_len_16: assert property (  // [RULE1]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (st_reg == ST_RUN && idle_halt_i && clock_divide_select_i < DSEL_DIV10)
    |-> ##16 core_clk_en_o ##1 !core_clk_en_o)
    else $error("core clock not stopped 16 cycles after idle");

  a_flush_len_32: assert property (  // [RULE1]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (st_reg == ST_RUN && idle_halt_i && clock_divide_select_i == DSEL_DIV10)
    |-> ##32 core_clk_en_o ##1 !core_clk_en_o)
    else $error("core clock not stopped 32 cycles after idle");

  a_flush_len_64: assert property (  // [RULE1]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (st_reg == ST_RUN && idle_halt_i && clock_divide_select_i == DSEL_DIV11)
    |-> ##64 core_clk_en_o ##1 !core_clk_en_o)
    else $error("core clock not stopped 64 cycles after idle");

  a_ext_access_fail: assert property (  // [RULE2]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (st_reg == ST_FLUSH && seq_if.done) |=> (ext_mem_fail_o == $past(ext_mem_busy_i)))
    else $error("pending external access not flagged at flush end");

  a_halt_gates_off: assert property (  // [RULE3]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (st_reg == ST_HALTED) |-> (!periph_clk_en_o && !pll_en_o && !core_clk_en_o && halted_o))
    else $error("clocks or pll still on while halted");

  a_crystal_osc_off: assert property (  // [RULE4]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (st_reg == ST_HALTED && $past(crystal_source_i)) |-> !osc_en_o)
    else $error("oscillator running while halted on crystal");

  a_wake_osc_on: assert property (  // [RULE5]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (st_reg == ST_HALTED && !wake_pin_i) |-> ##2 (osc_en_o && st_reg == ST_OSC_WAIT))
    else $error("low wake pin did not restart oscillator");

  a_lock_interval: assert property (  // [RULE7] [RULE8]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(core_clk_en_o) |-> (lock_obs_reg == LOCK_W'(LOCK_CYC)))
    else $error("lock interval length wrong");

  a_clocks_back: assert property (  // [RULE9]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(core_clk_en_o) |-> (periph_clk_en_o && !halted_o && osc_en_o))
    else $error("clocks not released together at lock end");

  a_wake_irq: assert property (  // [RULE9]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    cpu_resume_o |-> (wake_irq_o == $past(wake_int_en_i)))
    else $error("wake interrupt not matched to enable at resume");

  a_xclk_low_time: assert property (  // [RULE11]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (st_reg == ST_RUN && idle_halt_i) |-> ##32 external_clock_output_en_o
    ##1 !external_clock_output_en_o)
    else $error("external clock not low 32 cycles after idle");

  a_resume_ram: assert property (  // [RULE12]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    ($rose(core_clk_en_o) && !$past(flash_sleep_i)) |-> ##35 cpu_resume_o)
    else $error("resume from ram not after 35 cycles");

  a_lock_reload: assert property (  // [RULE13]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (st_reg == ST_FLUSH && seq_if.done) |=> (lock_if.count == LOCK_W'(LOCK_CYC)))
    else $error("lock counter not reloaded on halt entry");

  a_early_wake_held: assert property (  // [RULE10]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (st_reg == ST_HALTED && entry_reg < MIN_WAKE_CYC) |=> (st_reg == ST_HALTED))
    else $error("wake honoured too soon after idle");

endmodule

//--- core/hmws_pkg.sv
// constants, types and helpers shared by the halt entry and wake sequencer
package hmws_pkg;

  localparam int SEQ_CNT_W = 11;

  typedef logic [1:0]           hmws_dsel_type;
  typedef logic [SEQ_CNT_W-1:0] hmws_seq_cnt_type;
  typedef logic [5:0]           hmws_entry_cnt_type;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_FLUSH,
    ST_HALTED,
    ST_OSC_WAIT,
    ST_LOCK,
    ST_RESUME
  } hmws_state_type;

  // flush delay, system clock cycles, per divide select
  localparam hmws_seq_cnt_type FLUSH_DIV01_CYC = 11'h010;
  localparam hmws_seq_cnt_type FLUSH_DIV10_CYC = 11'h020;
  localparam hmws_seq_cnt_type FLUSH_DIV11_CYC = 11'h040;
  localparam hmws_dsel_type    DSEL_DIV10      = 2'h2;
  localparam hmws_dsel_type    DSEL_DIV11      = 2'h3;

  // external clock output goes low this many cycles after the idle instruction
  localparam hmws_entry_cnt_type XCLK_LOW_CYC  = 6'h20;
  // earliest cycle after the idle instruction at which a wake is honoured
  localparam hmws_entry_cnt_type MIN_WAKE_CYC  = 6'h04;
  localparam hmws_entry_cnt_type ENTRY_CNT_RST = 6'h00;

  // lock-up interval, oscillator clock cycles
  localparam int LOCK_CYC_DEF = 131072;
  localparam int LOCK_W_DEF   = 18;

  // lock done to execution resume, system clock cycles
  localparam hmws_seq_cnt_type RESUME_FLASH_CYC = 11'h465;
  localparam hmws_seq_cnt_type RESUME_SINGLE_ACCESS_RAM_CYC = 11'h023;
  localparam hmws_seq_cnt_type SEQ_CNT_RST      = 11'h000;

  function automatic hmws_seq_cnt_type hmws_flush_len(input hmws_dsel_type dsel);
    hmws_seq_cnt_type len;
    len = FLUSH_DIV01_CYC;
    if (dsel == DSEL_DIV10) begin
      len = FLUSH_DIV10_CYC;
    end else if (dsel == DSEL_DIV11) begin
      len = FLUSH_DIV11_CYC;
    end
    return len;
  endfunction

endpackage

//--- core/hmws_wake_detect.sv
// wake pin sampler: low level and falling edge
`timescale 1ns/1ps
module hmws_wake_detect (
  input  wire logic sys_clk_i,   // system clock
  input  wire logic rst_n_i,     // async reset, active low
  input  wire logic wake_pin_i,  // wake pin level
  output logic      wake_low_o,  // pin seen low last cycle
  output logic      wake_fall_o  // pin seen falling last cycle
);
  logic pin_reg;
  logic pin_next;
  logic prev_reg;
  logic prev_next;

  always_comb begin
    pin_next  = wake_pin_i;
    prev_next = pin_reg;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_reg  <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      pin_reg  <= pin_next;
      prev_reg <= prev_next;
    end
  end

  assign wake_low_o  = !pin_reg;
  assign wake_fall_o = prev_reg && !pin_reg;
endmodule
